// ==== rtl/pbm_pkg.sv ====
package pbm_pkg;
   localparam logic [7:0] IRQ_SOURCE_ADDR     = 8'h00;
   localparam logic [7:0] OP_MODE_ADDR        = 8'h09;
   localparam logic [7:0] GATEWAY_CONFIG_ADDR = 8'h0d;
   localparam logic [7:0] GATEWAY_BASE_ADDR   = 8'h0e;
   localparam logic [7:0] UNLOCK_HIGH_ADDR    = 8'hac;
   localparam logic [7:0] UNLOCK_LOW_ADDR     = 8'had;
   localparam logic [7:0] PARAM_STATUS_ADDR   = 8'h0f;
   localparam logic [7:0] SCAN_INTERVAL_LOC   = 8'hf9;
   localparam logic [7:0] RAW_BASE_LOC        = 8'h80;
   localparam logic [7:0] AVG_BASE_LOC        = 8'h9a;
   localparam logic [7:0] DELTA_BASE_LOC      = 8'hb4;
   localparam logic [7:0] KEY_HIGH_VALUE      = 8'h62;
   localparam logic [7:0] KEY_LOW_VALUE       = 8'h9d;
   localparam logic [7:0] TRIGGER_FIRST       = 8'ha5;
   localparam logic [7:0] TRIGGER_SECOND      = 8'h5a;
   localparam logic [7:0] SCAN_INTERVAL_RESET = 8'h0d;
   localparam int         BURN_DONE_BIT       = 6;
   localparam int         MONITOR_EN_BIT      = 2;
   localparam int         GW_DIR_BIT          = 3;
   localparam int         GW_MODE_LSB         = 4;
   localparam logic [1:0] GW_MODE_ON          = 2'h1;
   localparam logic [1:0] OP_MODE_SLEEP       = 2'h2;
   localparam logic [2:0] MAX_EFFECTIVE_BURNS = 3'h3;
   localparam int         CLK_HZ              = 50000000;
   localparam int         SCAN_UNIT_MS        = 15;
   localparam int         SCAN_UNIT_CYCLES    = CLK_HZ / 1000 * SCAN_UNIT_MS;
   localparam int         PARAM_DEPTH         = 128;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       stop;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pbm_req_s;

   typedef enum {
      PBM_KEY_IDLE,
      PBM_KEY_HIGH,
      PBM_KEY_LOW,
      PBM_KEY_TRIG1,
      PBM_KEY_ARMED
   } pbm_key_e;
endpackage : pbm_pkg

// ==== rtl/pbm_scan_timer.sv ====
`timescale 1ns/1ps
// monitor scan tick generator: period = interval x unit
module pbm_scan_timer #(
   parameter int UNIT_CYCLES = pbm_pkg::SCAN_UNIT_CYCLES
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_enable,
   input  wire logic [7:0] i_interval,
   output logic            o_tick
);
   logic [31:0] unit_reg;
   logic [7:0]  units_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         unit_reg  <= 32'h0;
         units_reg <= 8'h0;
         o_tick    <= 1'b0;
      end else if (!i_enable || i_interval == 8'h00) begin
         unit_reg  <= 32'h0;
         units_reg <= 8'h0;
         o_tick    <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (unit_reg == 32'(UNIT_CYCLES - 1)) begin
            unit_reg <= 32'h0;
            if (units_reg >= i_interval - 8'h01) begin
               units_reg <= 8'h0;
               o_tick    <= 1'b1;
            end else begin
               units_reg <= units_reg + 8'h01;
            end
         end else begin
            unit_reg <= unit_reg + 32'h1;
         end
      end
   end
endmodule : pbm_scan_timer

// ==== rtl/pbm_core.sv ====
`timescale 1ns/1ps
// Functional notes
// - burn copies whole shadow memory, three effective
// - burn done sets source bit 6, irq
// - reset reloads burned parameters into shadow memory
// - burn count readable in status bits 2:0
// - delivered empty, factory defaults feed shadow memory
// - fourth burn switches permanently to factory defaults
// - two trigger writes then stop start burn
// - config bit 2 enables monitor mode
// - monitor interrupt once per complete scan
// - scan interval is value times 15 ms
// - scan interval written via gateway write
// - reading irq source clears monitor interrupt
// - delta values from 0xb4, msb first
// - values signed 16 bit, refreshed each scan
// - raw from 0x80, average from 0x9a
// - monitor data read via gateway read
module pbm_core #(
   parameter int CHANNELS    = 12,
   parameter int UNIT_CYCLES = pbm_pkg::SCAN_UNIT_CYCLES
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   input  wire pbm_pkg::pbm_req_s      i_req,
   input  wire logic [2:0]             i_nvm_count,
   input  wire logic [16*CHANNELS-1:0] i_raw,
   input  wire logic [16*CHANNELS-1:0] i_avg,
   input  wire logic [16*CHANNELS-1:0] i_delta,
   input  wire logic [7:0]             i_nvm_rdata,
   input  wire logic [7:0]             i_factory_rdata,
   output logic [7:0]                  o_rdata,
   output logic                        o_irq_n_out,
   output logic                        o_burn_start,
   output logic [2:0]                  o_burn_count,
   output logic                        o_use_factory,
   output logic                        o_monitor_on,
   output logic [6:0]                  o_param_addr
);
   localparam int PD = pbm_pkg::PARAM_DEPTH;

   logic [1:0]       rst_sync_reg;
   logic             rst_n;
   pbm_pkg::pbm_key_e key_reg;
   logic [7:0]       cfg_reg;
   logic [7:0]       base_reg;
   logic [1:0]       opmode_reg;
   logic [7:0]       scan_reg;
   logic [7:0]       irq_src_reg;
   logic             mon_irq_reg;
   logic [2:0]       count_reg;
   logic             factory_reg;
   logic             burning_reg;
   logic [6:0]       ptr_reg;
   logic             loading_reg;
   logic [7:0]       shadow_mem [PD];
   logic [7:0]       snap_mem [256];
   logic             tick;
   logic             gw_on;
   logic [7:0]       loc;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) rst_sync_reg <= 2'b00;
      else            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   function automatic logic is_wr(pbm_pkg::pbm_req_s r, logic [7:0] a);
      return r.wr && r.addr == a;
   endfunction : is_wr

   // empty or exhausted nvm selects factory set
   function automatic logic factory_sel(logic [2:0] n);
      return n == 3'h0 || n > pbm_pkg::MAX_EFFECTIVE_BURNS;
   endfunction : factory_sel

   assign gw_on = cfg_reg[pbm_pkg::GW_MODE_LSB +: 2] == pbm_pkg::GW_MODE_ON;
   assign loc   = base_reg + {5'h0, i_req.addr[2:0]};

   ////////////////////////////////////////////////////////////////////////
   // plain registers, written even while the gateway owns addresses 0..7
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg    <= 8'h00;
         base_reg   <= 8'h00;
         opmode_reg <= 2'h0;
      end else begin
         if (is_wr(i_req, pbm_pkg::GATEWAY_CONFIG_ADDR)) cfg_reg <= i_req.wdata;
         if (is_wr(i_req, pbm_pkg::GATEWAY_BASE_ADDR))   base_reg <= i_req.wdata;
         if (is_wr(i_req, pbm_pkg::OP_MODE_ADDR))        opmode_reg <= i_req.wdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unlock key sequence
   // any other write aborts the sequence
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_reg      <= pbm_pkg::PBM_KEY_IDLE;
         o_burn_start <= 1'b0;
      end else begin
         o_burn_start <= 1'b0;
         if (i_req.wr) begin
            key_reg <= pbm_pkg::PBM_KEY_IDLE;
            case (key_reg)
               pbm_pkg::PBM_KEY_IDLE:
                  if (is_wr(i_req, pbm_pkg::UNLOCK_HIGH_ADDR) &&
                      i_req.wdata == pbm_pkg::KEY_HIGH_VALUE)
                     key_reg <= pbm_pkg::PBM_KEY_HIGH;
               pbm_pkg::PBM_KEY_HIGH:
                  if (is_wr(i_req, pbm_pkg::UNLOCK_LOW_ADDR) &&
                      i_req.wdata == pbm_pkg::KEY_LOW_VALUE)
                     key_reg <= pbm_pkg::PBM_KEY_LOW;
               pbm_pkg::PBM_KEY_LOW:
                  if (is_wr(i_req, pbm_pkg::GATEWAY_BASE_ADDR) &&
                      i_req.wdata == pbm_pkg::TRIGGER_FIRST)
                     key_reg <= pbm_pkg::PBM_KEY_TRIG1;
               pbm_pkg::PBM_KEY_TRIG1:
                  if (is_wr(i_req, pbm_pkg::GATEWAY_BASE_ADDR) &&
                      i_req.wdata == pbm_pkg::TRIGGER_SECOND)
                     key_reg <= pbm_pkg::PBM_KEY_ARMED;
               default: key_reg <= pbm_pkg::PBM_KEY_IDLE;
            endcase
         end else if (i_req.stop && key_reg == pbm_pkg::PBM_KEY_ARMED) begin
            key_reg <= pbm_pkg::PBM_KEY_IDLE;
            if (opmode_reg != pbm_pkg::OP_MODE_SLEEP && !burning_reg && !loading_reg)
               o_burn_start <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // burn walks the whole shadow memory, one byte a cycle
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         burning_reg  <= 1'b0;
         loading_reg  <= 1'b1;
         ptr_reg      <= 7'h0;
         count_reg    <= 3'h0;
         factory_reg  <= 1'b1;
         o_param_addr <= 7'h0;
      end else begin
         // address output tracks the pointer so nvm data matches the byte written
         if (loading_reg) begin
            // reload; count captured from nvm after release
            count_reg    <= i_nvm_count;
            // empty nvm or exhausted selects factory set
            factory_reg  <= factory_sel(i_nvm_count);
            ptr_reg      <= ptr_reg + 7'h1;
            o_param_addr <= ptr_reg + 7'h1;
            if (ptr_reg == 7'(PD - 1)) loading_reg <= 1'b0;
         end else if (o_burn_start) begin
            burning_reg  <= 1'b1;
            ptr_reg      <= 7'h0;
            o_param_addr <= 7'h0;
         end else if (burning_reg) begin
            ptr_reg      <= ptr_reg + 7'h1;
            o_param_addr <= ptr_reg + 7'h1;
            if (ptr_reg == 7'(PD - 1)) begin
               burning_reg <= 1'b0;
               // count increments; fourth burn falls back for good
               if (count_reg != 3'h7) count_reg <= count_reg + 3'h1;
               factory_reg <= count_reg >= pbm_pkg::MAX_EFFECTIVE_BURNS;
            end
         end
      end
   end

   // shadow memory refill, and gateway writes
   always_ff @(posedge i_clk) begin
      if (loading_reg)
         shadow_mem[ptr_reg] <= factory_sel(i_nvm_count) ? i_factory_rdata : i_nvm_rdata;
      else if (gw_on && !cfg_reg[pbm_pkg::GW_DIR_BIT] && i_req.wr &&
               i_req.addr[7:3] == 5'h0 && !loc[7])
         shadow_mem[loc[6:0]] <= i_req.wdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // scan interval through the gateway write path
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) scan_reg <= pbm_pkg::SCAN_INTERVAL_RESET;
      else if (gw_on && !cfg_reg[pbm_pkg::GW_DIR_BIT] && i_req.wr &&
               i_req.addr[7:3] == 5'h0 && loc == pbm_pkg::SCAN_INTERVAL_LOC &&
               i_req.wdata != 8'h00)
         scan_reg <= i_req.wdata;
   end

   assign o_monitor_on = cfg_reg[pbm_pkg::MONITOR_EN_BIT];

   // period = interval x 15 ms
   pbm_scan_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_timer (
      .i_clk      (i_clk),
      .i_rst_n    (rst_n),
      .i_enable   (cfg_reg[pbm_pkg::MONITOR_EN_BIT]),
      .i_interval (scan_reg),
      .o_tick     (tick)
   );

   // snapshot of all channels each scan, msb at lower location
   // one process owns the whole snapshot array
   always_ff @(posedge i_clk) begin
      if (tick) begin
         for (int ch = 0; ch < CHANNELS; ch++) begin
            snap_mem[pbm_pkg::RAW_BASE_LOC + 8'(2*ch)]     <= i_raw[16*ch+8 +: 8];
            snap_mem[pbm_pkg::RAW_BASE_LOC + 8'(2*ch+1)]   <= i_raw[16*ch +: 8];
            snap_mem[pbm_pkg::AVG_BASE_LOC + 8'(2*ch)]     <= i_avg[16*ch+8 +: 8];
            snap_mem[pbm_pkg::AVG_BASE_LOC + 8'(2*ch+1)]   <= i_avg[16*ch +: 8];
            snap_mem[pbm_pkg::DELTA_BASE_LOC + 8'(2*ch)]   <= i_delta[16*ch+8 +: 8];
            snap_mem[pbm_pkg::DELTA_BASE_LOC + 8'(2*ch+1)] <= i_delta[16*ch +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt sources; set wins over read clear
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_src_reg <= 8'h00;
         mon_irq_reg <= 1'b0;
         o_irq_n_out <= 1'b1;
      end else begin
         if (i_req.rd && i_req.addr == pbm_pkg::IRQ_SOURCE_ADDR && !gw_on) begin
            irq_src_reg <= 8'h00;
            mon_irq_reg <= 1'b0;
         end
         if (burning_reg && ptr_reg == 7'(PD - 1))
            irq_src_reg[pbm_pkg::BURN_DONE_BIT] <= 1'b1;
         if (tick) mon_irq_reg <= 1'b1;
         o_irq_n_out <= !((irq_src_reg != 8'h00) || mon_irq_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status and gateway read
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) o_rdata <= 8'h00;
      else if (i_req.rd) begin
         if (gw_on && i_req.addr[7:3] == 5'h0)
            o_rdata <= loc[7] ? snap_mem[loc] : shadow_mem[loc[6:0]];
         else begin
            case (i_req.addr)
               pbm_pkg::IRQ_SOURCE_ADDR:     o_rdata <= irq_src_reg;
               pbm_pkg::GATEWAY_CONFIG_ADDR: o_rdata <= cfg_reg;
               pbm_pkg::GATEWAY_BASE_ADDR:   o_rdata <= base_reg;
               pbm_pkg::OP_MODE_ADDR:        o_rdata <= {6'h0, opmode_reg};
               pbm_pkg::PARAM_STATUS_ADDR:   o_rdata <= {5'h0, count_reg};
               default:                      o_rdata <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_burn_count  <= 3'h0;
         o_use_factory <= 1'b1;
      end else begin
         o_burn_count  <= count_reg;
         o_use_factory <= factory_reg;
      end
   end
endmodule : pbm_core

// ==== test/pbm_checker.sv ====
`timescale 1ns/1ps
module pbm_checker (
   input wire logic              i_clk,
   input wire logic              i_reset_n,
   input wire pbm_pkg::pbm_req_s i_req,
   input wire logic [7:0]        o_rdata,
   input wire logic              o_irq_n_out,
   input wire logic              o_burn_start,
   input wire logic [2:0]        o_burn_count,
   input wire logic              o_use_factory,
   input wire logic              o_monitor_on,
   input wire logic [6:0]        o_param_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   property p_burn_pulse; o_burn_start |=> !o_burn_start; endproperty
   a_burn_pulse: assert property (p_burn_pulse) else $error("burn pulse too long");
   property p_burn_cause; o_burn_start |-> $past(i_req.stop); endproperty
   a_burn_cause: assert property (p_burn_cause) else $error("burn without stop");
   property p_burn_walk;
      o_burn_start |=> o_param_addr == 7'h00 ##127 o_param_addr == 7'h7f;
   endproperty
   a_burn_walk: assert property (p_burn_walk) else $error("copy walk wrong");
   property p_burn_irq; o_burn_start |-> ##130 !o_irq_n_out; endproperty
   a_burn_irq: assert property (p_burn_irq) else $error("no burn done irq");
   property p_burn_count;
      o_burn_start |-> ##130 o_burn_count == $past(o_burn_count, 130) + 3'h1;
   endproperty
   a_burn_count: assert property (p_burn_count) else $error("count not stepped");
   property p_factory;
      (o_burn_count == 3'h0 || o_burn_count > 3'h3) [*2] |-> o_use_factory;
   endproperty
   a_factory: assert property (p_factory) else $error("factory set not used");
   property p_mon_en;
      i_req.wr && i_req.addr == pbm_pkg::GATEWAY_CONFIG_ADDR
         |=> o_monitor_on == $past(i_req.wdata[2]);
   endproperty
   a_mon_en: assert property (p_mon_en) else $error("monitor enable wrong");
   property p_irq_clear;
      i_req.rd && i_req.addr == pbm_pkg::IRQ_SOURCE_ADDR && !o_monitor_on |-> ##2 o_irq_n_out;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
   property p_status;
      i_req.rd && i_req.addr == pbm_pkg::PARAM_STATUS_ADDR |-> ##2 o_rdata[2:0] == o_burn_count;
   endproperty
   a_status: assert property (p_status) else $error("status count wrong");
   property p_rdata_hold; !$past(i_req.rd) && !$past(i_req.rd, 2) |-> $stable(o_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   c_burn: cover property (o_burn_start);
   c_mon_irq: cover property (o_monitor_on && $fell(o_irq_n_out));
   c_status: cover property (i_req.rd && i_req.addr == pbm_pkg::PARAM_STATUS_ADDR);
endmodule : pbm_checker

// ==== test/pbm_host.sv ====
`timescale 1ns/1ps
module pbm_host (
   input  wire logic         i_clk,
   output pbm_pkg::pbm_req_s o_req
);
   initial o_req = '0;
   task automatic put(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_req = {k, a, d};
      @(negedge i_clk);
      // idle bus carries the inverse of the last address and data bytes
      o_req = {3'h0, ~a, ~d};
   endtask : put
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(3'h4, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      put(3'h2, a, 8'h00);
   endtask : rd
   task automatic burn();
      wr(8'hac, 8'h62);
      wr(8'had, 8'h9d);
      wr(8'h0e, 8'ha5);
      wr(8'h0e, 8'h5a);
      put(3'h1, 8'h00, 8'h00);
   endtask : burn
   // interval byte at offset 1 of base 0xf8
   task automatic scan_write(input logic [7:0] v);
      wr(8'h0d, 8'h14);
      wr(8'h0e, 8'hf8);
      for (int i = 0; i < 8; i++)
         wr(8'(i), i == 1 ? v : 8'h00);
      wr(8'h0d, 8'h04);
   endtask : scan_write
endmodule : pbm_host

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic              i_clk, i_reset_n, irq_n, burn_start, use_factory, pend1, pend2;
   pbm_pkg::pbm_req_s req;
   logic [2:0]        nvm_count, burn_count;
   logic [191:0]      raw, avg, delta;
   logic [7:0]        rdata, mk, exp_q[$], msk_q[$];
   logic [6:0]        param_addr;
   int                bad_count, cmp_count, cycles, t0, t1, seed;
   pbm_core #(.CHANNELS(12), .UNIT_CYCLES(10)) u_pbm_core (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_nvm_count(nvm_count),
      .i_raw(raw), .i_avg(avg), .i_delta(delta),
      .i_nvm_rdata({1'b0, param_addr} ^ 8'hc3), .i_factory_rdata({1'b0, param_addr} ^ 8'h3c),
      .o_rdata(rdata), .o_irq_n_out(irq_n), .o_burn_start(burn_start),
      .o_burn_count(burn_count), .o_use_factory(use_factory), .o_monitor_on(),
      .o_param_addr(param_addr));
   pbm_host u_pbm_host (.i_clk(i_clk), .o_req(req));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      pend1 <= req.rd;
      pend2 <= pend1;
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         wrap_up();
      end
   end
   // nvm side counts the burns it has taken
   always @(negedge i_clk) begin
      if (burn_start === 1'b1) nvm_count <= nvm_count + 3'h1;
      if (pend2 === 1'b1) begin
         mk = msk_q.pop_front();
         check("rdata", exp_q.pop_front() & mk, rdata & mk);
      end
   end
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (e !== s) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, e, s);
      end
   endtask : check
   task automatic wrap_up();
      if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      u_pbm_host.rd(a);
   endtask : rd_exp
   task automatic do_reset();
      @(negedge i_clk);
      i_reset_n = 1'b0;
      repeat (16) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (140) @(negedge i_clk);
   endtask : do_reset
   task automatic wait_irq();
      t1 = 0;
      repeat (2) @(negedge i_clk);
      while (irq_n !== 1'b0 && t1 < 300) begin
         @(negedge i_clk);
         t1++;
      end
   endtask : wait_irq
   // msb at even offset, channel 0 in the low bits; bit 8 marks a mapped location
   function automatic logic [8:0] mon_exp(input logic [7:0] loc);
      logic [191:0] v;
      logic [7:0]   off;
      v = loc >= 8'hb4 ? delta : loc >= 8'h9a ? avg : raw;
      off = loc - (loc >= 8'hb4 ? 8'hb4 : loc >= 8'h9a ? 8'h9a : 8'h80);
      return {off < 8'd24, v[off[7:1] * 16 + (off[0] ? 0 : 8) +: 8]};
   endfunction : mon_exp
   task automatic gw_read(input logic [7:0] base, input int kind);
      logic [8:0] e;
      u_pbm_host.wr(8'h0d, kind == 2 ? 8'h1c : 8'h18);
      u_pbm_host.wr(8'h0e, base);
      for (int i = 0; i < 8; i++) begin
         e = kind == 2 ? mon_exp(base + 8'(i))
                       : {1'b1, (base + 8'(i)) ^ (kind == 1 ? 8'hc3 : 8'h3c)};
         rd_exp(8'(i), e[7:0], {8{e[8]}});
      end
      u_pbm_host.wr(8'h0d, kind == 2 ? 8'h04 : 8'h00);
   endtask : gw_read
   task automatic burn_chk(input logic [2:0] n);
      u_pbm_host.burn();
      wait_irq();
      check("irq_n_out", 8'h00, {7'h0, irq_n});
      rd_exp(8'h00, 8'h40, 8'h40);
      rd_exp(pbm_pkg::PARAM_STATUS_ADDR, {5'h0, n}, 8'h07);
      check("use_factory", {7'h0, n > 3'h3}, {7'h0, use_factory});
      check("irq_n_out", 8'h01, {7'h0, irq_n});
   endtask : burn_chk
   task automatic scan_chk(input int p);
      for (int k = 0; k < 3; k++) begin
         wait_irq();
         if (k == 2) check("scan_period", 8'(p), 8'(cycles - t0));
         t0 = cycles;
         rd_exp(8'h00, 8'h00, 8'h40);
      end
   endtask : scan_chk
   initial begin
      seed = $urandom(6);
      {i_reset_n, nvm_count, pend1, pend2, bad_count, cmp_count, cycles} = '0;
      for (int i = 0; i < 6; i++) begin
         raw[i*32 +: 32] = $urandom();
         avg[i*32 +: 32] = $urandom();
         delta[i*32 +: 32] = $urandom();
      end
      do_reset();
      check("use_factory", 8'h01, {7'h0, use_factory});
      rd_exp(pbm_pkg::PARAM_STATUS_ADDR, 8'h00, 8'h07);
      gw_read(8'h00, 0);
      burn_chk(3'h1);
      do_reset();
      check("use_factory", 8'h00, {7'h0, use_factory});
      gw_read(8'h00, 1);
      u_pbm_host.wr(8'hac, 8'h62);
      u_pbm_host.wr(8'had, 8'h9c);
      u_pbm_host.wr(8'h0e, 8'ha5);
      u_pbm_host.wr(8'h0e, 8'h5a);
      u_pbm_host.put(3'h1, 8'h00, 8'h00);
      u_pbm_host.wr(pbm_pkg::OP_MODE_ADDR, 8'h02);
      u_pbm_host.burn();
      u_pbm_host.wr(pbm_pkg::OP_MODE_ADDR, 8'h00);
      repeat (150) @(negedge i_clk);
      check("burn_events", 8'h01, {5'h0, nvm_count});
      for (int n = 2; n < 5; n++) burn_chk(3'(n));
      do_reset();
      check("use_factory", 8'h01, {7'h0, use_factory});
      gw_read(8'h00, 0);
      u_pbm_host.wr(8'h0d, 8'h04);
      for (int i = 0; i < 3; i++) begin
         if (i > 0) u_pbm_host.scan_write(i == 1 ? 8'h02 : 8'h00);
         scan_chk(i == 0 ? 130 : 20);
      end
      gw_read(8'h80, 2);
      gw_read(8'h98, 2);
      gw_read(8'hb0, 2);
      wrap_up();
   end
endmodule : testbench
bind pbm_core pbm_checker u_pbm_checker (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .o_rdata(o_rdata),
   .o_irq_n_out(o_irq_n_out), .o_burn_start(o_burn_start), .o_burn_count(o_burn_count),
   .o_use_factory(o_use_factory), .o_monitor_on(o_monitor_on), .o_param_addr(o_param_addr));
